// ### hw/dyno_alarm_supervisor.sv
/*
 * dyno_alarm_supervisor: overload detection, alarm latching, priority,
 * relay and brake excitation response for two torque-speed channels.
 * Assumes all inputs synchronous to MCLK_I; the speed strobe pulses once
 * per control-loop speed sample; key presses arrive as one-cycle pulses.
 */
`timescale 1ns/1ns
module dyno_alarm_supervisor #(
   parameter logic [31:0] PERSIST_CYC = dyno_alarm_pkg::OL_PERSIST_CYC,
   parameter logic [31:0] HOLD_CYC = dyno_alarm_pkg::EXC_HOLD_CYC,
   parameter logic [31:0] BLINK_CYC = dyno_alarm_pkg::BLINK_HALF_CYC
) (
   // clock and reset
   input wire logic MCLK_I,
   input wire logic RST_I,
   // measurements
   input wire dyno_alarm_pkg::chan_meas_t CH1_MEAS_I,
   input wire dyno_alarm_pkg::chan_meas_t CH2_MEAS_I,
   input wire logic SPEED_STROBE_I,
   input wire logic [15:0] GLOBAL_POWER_I,
   // configuration
   input wire dyno_alarm_pkg::cfg_wr_t CFG_I,
   input wire logic TANDEM_I,
   input wire logic BRAKE1_POWDER_I,
   input wire logic BRAKE2_POWDER_I,
   // automatic and auxiliary conditions
   input wire logic SUPPLY_IN_USE_I,
   input wire logic TEMP_FAULT_I,
   input wire logic ELEC_FAULT_I,
   input wire logic [4:0] AUX_FAULT_I,
   // operator panel
   input wire logic KEY_PRESS_I,
   input wire logic KEY_SHIFT_I,
   // drive side
   input wire logic [15:0] EXC_DEMAND_I,
   input wire logic STANDBY_I,
   // outputs
   output logic RELAY_ENERGIZE_O,
   output logic [15:0] EXC_CMD_O,
   output logic STANDBY_O,
   output logic [3:0] OL_BLINK_O,
   output logic [3:0] ALARM_CODE_O,
   output logic [8:0] LATCHED_O
);
   import dyno_alarm_pkg::*;

   // value above 120% of limit, i.e. 5*v > 6*l
   function automatic logic over120(input logic [15:0] v, input logic [15:0] l);
      logic [18:0] a;
      logic [18:0] b;
      a = {1'b0, v, 2'b00} + {3'b000, v};
      b = {1'b0, l, 2'b00} + {2'b00, l, 1'b0};
      return a > b;
   endfunction

   // code of the highest-priority set source, 1 = temperature
   function automatic logic [3:0] prio(input logic [8:0] s);
      logic [3:0] c;
      c = CODE_NONE;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (s[i]) begin
            c = 4'(i + 1);
         end
      end
      return c;
   endfunction

   logic [15:0] pwr_lim_reg [2];
   logic [15:0] spd_lim_reg [2];
   logic [15:0] glob_lim_reg;
   logic [7:0] en_reg;
   logic [1:0] spd_over_reg;
   logic [1:0] spd_hi_reg;
   logic [31:0] tmr_reg [4];
   logic [3:0] lat_reg;
   logic glob_lat_reg;
   logic [1:0] auto_lat_reg;
   logic [4:0] aux_lat_reg;
   exc_state_t st_reg;
   logic [31:0] hold_reg;
   logic [31:0] blink_reg;
   logic phase_reg;

   // configuration writes; limits and enables reset to defaults
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         pwr_lim_reg[0] <= PWR_LIMIT_RST;
         pwr_lim_reg[1] <= PWR_LIMIT_RST;
         spd_lim_reg[0] <= SPD_LIMIT_RST;
         spd_lim_reg[1] <= SPD_LIMIT_RST;
         glob_lim_reg <= GLOB_LIMIT_RST;
         en_reg <= EN_RST;
      end else if (CFG_I.wr) begin
         unique case (CFG_I.sel)
            CFG_PWR_LIM1: pwr_lim_reg[0] <= CFG_I.data;
            CFG_PWR_LIM2: pwr_lim_reg[1] <= CFG_I.data;
            CFG_SPD_LIM1: spd_lim_reg[0] <= CFG_I.data;
            CFG_SPD_LIM2: spd_lim_reg[1] <= CFG_I.data;
            CFG_ENABLES: en_reg <= CFG_I.data[EN_W-1:0];
            CFG_GLOB_LIM: glob_lim_reg <= CFG_I.data;
            default: ;
         endcase
      end
   end

   // speed compared only on each control-loop sample
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         spd_over_reg <= 2'b00;
         spd_hi_reg <= 2'b00;
      end else if (SPEED_STROBE_I) begin
         spd_over_reg[0] <= CH1_MEAS_I.speed > spd_lim_reg[0];
         spd_over_reg[1] <= CH2_MEAS_I.speed > spd_lim_reg[1];
         spd_hi_reg[0] <= over120(CH1_MEAS_I.speed, spd_lim_reg[0]);
         spd_hi_reg[1] <= over120(CH2_MEAS_I.speed, spd_lim_reg[1]);
      end
   end

   // monitored conditions, index 0/1 power ch1/ch2, 2/3 speed ch1/ch2
   wire [3:0] ch_en = {en_reg[1], en_reg[0], en_reg[1], en_reg[0]};
   wire [1:0] pwr_over = {CH2_MEAS_I.power > pwr_lim_reg[1], CH1_MEAS_I.power > pwr_lim_reg[0]};
   wire [1:0] pwr_hi = {over120(CH2_MEAS_I.power, pwr_lim_reg[1]),
                        over120(CH1_MEAS_I.power, pwr_lim_reg[0])};
   wire [3:0] ol_mon = {spd_over_reg, pwr_over} & ch_en;
   wire [3:0] hi_mon = {spd_hi_reg, pwr_hi} & ch_en;
   wire [3:0] persist_done;
   wire [3:0] trip;
   wire key_clr = KEY_PRESS_I & ~KEY_SHIFT_I;

   // persistence timers restart when value drops to limit
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         for (int k = 0; k < 4; k++) begin
            tmr_reg[k] <= 32'h0000_0000;
         end
      end else begin
         for (int k = 0; k < 4; k++) begin
            if (!ol_mon[k]) begin
               tmr_reg[k] <= 32'h0000_0000;
            end else if (tmr_reg[k] != PERSIST_CYC) begin
               tmr_reg[k] <= tmr_reg[k] + 32'h0000_0001;
            end
         end
      end
   end

   // trip on 120% or on persisted overload
   generate
      for (genvar g = 0; g < 4; g++) begin : g_trip
         assign persist_done[g] = tmr_reg[g] == PERSIST_CYC;
         assign trip[g] = hi_mon[g] | (ol_mon[g] & persist_done[g]);
      end
   endgenerate

   // global, automatic and auxiliary conditions
   wire glob_act = TANDEM_I & (BRAKE1_POWDER_I == BRAKE2_POWDER_I) & en_reg[EN_GLOB];
   wire glob_trip = glob_act & (GLOBAL_POWER_I > glob_lim_reg);
   wire [1:0] auto_cond = {ELEC_FAULT_I, TEMP_FAULT_I} & {2{SUPPLY_IN_USE_I}};
   wire [4:0] aux_cond = AUX_FAULT_I & en_reg[EN_AUX_LO+4:EN_AUX_LO];

   // latch next values: set wins over a key clear
   wire [3:0] lat_next = trip | (lat_reg & ~({4{key_clr}} & ~ol_mon));
   wire glob_next = glob_trip | (glob_lat_reg & ~key_clr);
   wire [1:0] auto_next = auto_cond | (auto_lat_reg & ~{2{key_clr}});
   wire [4:0] aux_next = aux_cond | (aux_lat_reg & ~{5{key_clr}});
   wire [8:0] src_next = {glob_next | lat_next[0] | lat_next[1],
                          lat_next[2] | lat_next[3], aux_next, auto_next};
   wire stop_next = |lat_next | glob_next;
   wire stop_trig = |trip | glob_trip;

   // alarm latches and presented outputs
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         lat_reg <= 4'h0;
         glob_lat_reg <= 1'b0;
         auto_lat_reg <= 2'b00;
         aux_lat_reg <= 5'h00;
         RELAY_ENERGIZE_O <= 1'b1;
         ALARM_CODE_O <= CODE_NONE;
         LATCHED_O <= 9'h000;
         STANDBY_O <= 1'b0;
      end else begin
         lat_reg <= lat_next;
         glob_lat_reg <= glob_next;
         auto_lat_reg <= auto_next;
         aux_lat_reg <= aux_next;
         RELAY_ENERGIZE_O <= ~|src_next;
         ALARM_CODE_O <= prio(src_next);
         LATCHED_O <= src_next;
         STANDBY_O <= STANDBY_I;
      end
   end

   // excitation: follow demand, freeze on trip, then force zero
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_reg <= EXC_FOLLOW;
         hold_reg <= 32'h0000_0000;
         EXC_CMD_O <= 16'h0000;
      end else begin
         unique case (st_reg)
            EXC_FOLLOW: begin
               hold_reg <= 32'h0000_0000;
               if (stop_trig) begin
                  st_reg <= EXC_HOLD;
               end else begin
                  EXC_CMD_O <= EXC_DEMAND_I;
               end
            end
            EXC_HOLD: begin
               hold_reg <= hold_reg + 32'h0000_0001;
               if (!stop_next) begin
                  st_reg <= EXC_FOLLOW;
               end else if (hold_reg == HOLD_CYC - 32'h0000_0001) begin
                  st_reg <= EXC_ZERO;
                  EXC_CMD_O <= 16'h0000;
               end
            end
            EXC_ZERO: begin
               EXC_CMD_O <= 16'h0000;
               if (!stop_next) begin
                  st_reg <= EXC_FOLLOW;
               end
            end
         endcase
      end
   end

   // blink phase and overload indications
   wire [3:0] ol_disp = {ol_mon[3:2] & ~hi_mon[3:2], ol_mon[1:0]};
   always_ff @(posedge MCLK_I or posedge RST_I) begin
      if (RST_I) begin
         blink_reg <= 32'h0000_0000;
         phase_reg <= 1'b0;
         OL_BLINK_O <= 4'h0;
      end else begin
         if (blink_reg == BLINK_CYC - 32'h0000_0001) begin
            blink_reg <= 32'h0000_0000;
            phase_reg <= ~phase_reg;
         end else begin
            blink_reg <= blink_reg + 32'h0000_0001;
         end
         OL_BLINK_O <= ol_disp & {4{phase_reg}};
      end
   end

   // checks
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   AST_RELAY_OPEN: assert property (|LATCHED_O |-> !RELAY_ENERGIZE_O)
      else $error("relay energized with alarm latched");
   AST_RELAY_IDLE: assert property (LATCHED_O == 9'h000 |-> RELAY_ENERGIZE_O)
      else $error("relay dropped with no alarm");
   AST_PRIO_TEMP: assert property (LATCHED_O[0] |-> ALARM_CODE_O == 4'h1)
      else $error("temperature not presented first");
   AST_PRIO_POWER: assert property ((LATCHED_O == 9'h100) |-> ALARM_CODE_O == 4'h9)
      else $error("power alone not presented as code nine");
   AST_DISABLED_QUIET: assert property ((!en_reg[0] && !lat_reg[0]) |=> !lat_reg[0])
      else $error("disabled channel raised power alarm");
   AST_HI_LATCH: assert property (hi_mon[0] |=> lat_reg[0] && !RELAY_ENERGIZE_O)
      else $error("power over 120 percent did not latch");
   AST_SPD_HI: assert property (hi_mon[2] |=> lat_reg[2] ##0 LATCHED_O[7])
      else $error("overspeed did not latch");
   AST_HOLD_FREEZE: assert property ((st_reg == EXC_HOLD) && $past(st_reg == EXC_HOLD)
      |-> $stable(EXC_CMD_O))
      else $error("excitation moved during hold");
   AST_ZERO: assert property (st_reg == EXC_ZERO |-> EXC_CMD_O == 16'h0000)
      else $error("excitation not zero after hold");
   AST_STANDBY: assert property (!$past(RST_I) |-> STANDBY_O == $past(STANDBY_I))
      else $error("standby altered");
   AST_GLOB_OFF: assert property ((!glob_act && !glob_lat_reg) |=> !glob_lat_reg)
      else $error("global alarm outside tandem pair");
   AST_GLOB_NOW: assert property (glob_trip |=> glob_lat_reg && !RELAY_ENERGIZE_O)
      else $error("global alarm not latched at once");
   AST_KEY_CLEAR: assert property ((key_clr && !ol_mon[0] && lat_reg[0]) |=> !lat_reg[0])
      else $error("key did not clear gone condition");
   AST_TMR_RESTART: assert property (!ol_mon[1] |=> tmr_reg[1] == 32'h0000_0000)
      else $error("persistence timer not restarted");
   AST_SPD_SAMPLE: assert property (!SPEED_STROBE_I |=> $stable(spd_over_reg))
      else $error("speed compared off sample");
   AST_AUTO: assert property ((SUPPLY_IN_USE_I && TEMP_FAULT_I) |=> LATCHED_O[0])
      else $error("temperature alarm not automatic");
endmodule

// ### pkg/dyno_alarm_pkg.sv
/*
 * dyno_alarm_pkg: shared constants and types of the dynamometer alarm supervisor.
 * Assumes a 100 MHz system clock; power in watts, speed in RPM, both 16-bit unsigned.
 */
package dyno_alarm_pkg;
   // measurement and limit widths
   localparam int MEAS_W = 16;
   localparam int CODE_W = 4;
   localparam int NUM_SRC = 9;
   // limit reset values: 1 kW and 4000 RPM per channel, 2 kW global
   localparam logic [15:0] PWR_LIMIT_RST = 16'h03e8;
   localparam logic [15:0] SPD_LIMIT_RST = 16'h0fa0;
   localparam logic [15:0] GLOB_LIMIT_RST = 16'h07d0;
   // configuration selector codes for the write port
   localparam logic [2:0] CFG_PWR_LIM1 = 3'h0;
   localparam logic [2:0] CFG_PWR_LIM2 = 3'h1;
   localparam logic [2:0] CFG_SPD_LIM1 = 3'h2;
   localparam logic [2:0] CFG_SPD_LIM2 = 3'h3;
   localparam logic [2:0] CFG_ENABLES = 3'h4;
   localparam logic [2:0] CFG_GLOB_LIM = 3'h5;
   // enable word layout: [0] ch1, [1] ch2, [2] global, [7:3] auxiliary sources
   localparam int EN_W = 8;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam int EN_GLOB = 2;
   localparam int EN_AUX_LO = 3;
   // source positions, index 0 is the highest priority
   localparam int SRC_TEMP = 0;
   localparam int SRC_ELEC = 1;
   localparam int SRC_AUX_LO = 2; // external, air, water, clutch, torque
   localparam int SRC_SPEED = 7;
   localparam int SRC_POWER = 8;
   localparam logic [3:0] CODE_NONE = 4'h0;
   // timing: persistence 5 s, excitation hold 3 s, blink half period 250 ms
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned OL_PERSIST_MS = 5000;
   localparam int unsigned EXC_HOLD_MS = 3000;
   localparam int unsigned BLINK_HALF_MS = 250;
   localparam int unsigned CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
   localparam logic [31:0] OL_PERSIST_CYC = 32'(OL_PERSIST_MS * CYC_PER_MS);
   localparam logic [31:0] EXC_HOLD_CYC = 32'(EXC_HOLD_MS * CYC_PER_MS);
   localparam logic [31:0] BLINK_HALF_CYC = 32'(BLINK_HALF_MS * CYC_PER_MS);
   // one channel's measurement pair
   typedef struct packed {
      logic [15:0] power;
      logic [15:0] speed;
   } chan_meas_t;
   // configuration write strobe with its selector and data
   typedef struct packed {
      logic wr;
      logic [2:0] sel;
      logic [15:0] data;
   } cfg_wr_t;
   // excitation response states
   typedef enum logic [2:0] {
      EXC_FOLLOW = 3'b001,
      EXC_HOLD = 3'b010,
      EXC_ZERO = 3'b100
   } exc_state_t;
endpackage

// ### verif/far_side_model.sv
/*
 * far_side_model: front panel keys and brake excitation drive.
 * Assumes a free-running clock from the bench; keys are pressed by task call.
 */
`timescale 1ns/1ns
module far_side_model (
   // clock
   input wire logic clk_i,
   // panel and drive outputs
   output logic key_press_o,
   output logic key_shift_o,
   output logic [15:0] exc_demand_o
);
   // demand moves every cycle so a frozen command shows up
   initial begin
      key_press_o = 1'b0;
      key_shift_o = 1'b1;
      exc_demand_o = 16'h0100;
      forever begin
         @(negedge clk_i);
         exc_demand_o <= exc_demand_o + 16'h0001;
      end
   end
   // one key press pulse; shift line idles at the inverse
   task automatic press(input logic sh);
      @(negedge clk_i);
      key_press_o <= 1'b1;
      key_shift_o <= sh;
      @(negedge clk_i);
      key_press_o <= 1'b0;
      key_shift_o <= ~sh;
   endtask
endmodule

// ### verif/tb_top.sv
/*
 * tb_top: self-checking bench of the alarm supervisor.
 * Assumes short timing parameters; inputs change at the falling edge.
 */
`timescale 1ns/1ns
module tb_top;
   import dyno_alarm_pkg::*;
   localparam int HC = 12;
   logic clk = 1'b0, rst = 1'b1, strobe = 1'b0, tandem = 1'b0, pb1 = 1'b1, pb2 = 1'b0;
   logic supply = 1'b0, temp = 1'b0, elec = 1'b0, stby = 1'b1;
   logic [4:0] aux = 5'h00;
   logic [15:0] gpow = 16'h0000;
   chan_meas_t ch1 = '0, ch2 = '0;
   cfg_wr_t cfg = '0;
   logic kp, ks, relay, stby_o;
   logic [15:0] dem, exc, e;
   logic [3:0] blink, code;
   logic [8:0] lat;
   logic [31:0] v;
   int mismatches = 0, check_count = 0;
   always #5 clk = ~clk;
   dyno_alarm_supervisor #(.PERSIST_CYC(32'd20), .HOLD_CYC(32'd12), .BLINK_CYC(32'd4))
   dyno_alarm_supervisor_i (.MCLK_I(clk), .RST_I(rst), .CH1_MEAS_I(ch1), .CH2_MEAS_I(ch2),
      .SPEED_STROBE_I(strobe), .GLOBAL_POWER_I(gpow), .CFG_I(cfg), .TANDEM_I(tandem),
      .BRAKE1_POWDER_I(pb1), .BRAKE2_POWDER_I(pb2), .SUPPLY_IN_USE_I(supply),
      .TEMP_FAULT_I(temp), .ELEC_FAULT_I(elec), .AUX_FAULT_I(aux), .KEY_PRESS_I(kp),
      .KEY_SHIFT_I(ks), .EXC_DEMAND_I(dem), .STANDBY_I(stby), .RELAY_ENERGIZE_O(relay),
      .EXC_CMD_O(exc), .STANDBY_O(stby_o), .OL_BLINK_O(blink), .ALARM_CODE_O(code),
      .LATCHED_O(lat));
   far_side_model far_side_model_i (.clk_i(clk), .key_press_o(kp), .key_shift_o(ks),
      .exc_demand_o(dem));
   // reference priority: lowest set index wins, code is index plus one
   function automatic logic [15:0] exp_code(input logic [8:0] act);
      for (int i = 0; i < 9; i++) begin
         if (act[i]) return 16'(i + 1);
      end
      return 16'h0000;
   endfunction
   task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] g);
      check_count++;
      if (g !== ex) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // one control-loop speed sample
   task automatic strobe_speed();
      strobe = 1'b1;
      cyc(1);
      strobe = 1'b0;
   endtask
   // blink bit must show high at least once in ten cycles
   task automatic blink_seen(input int b);
      logic s;
      s = 1'b0;
      repeat (10) begin
         @(negedge clk);
         s = s | blink[b];
      end
      chk("blink", 16'h0001, {15'h0, s});
   endtask
   task automatic cfg_wr(input logic [2:0] s, input logic [15:0] d);
      @(negedge clk);
      cfg = '{wr: 1'b1, sel: s, data: d};
      @(negedge clk);
      cfg.wr = 1'b0;
   endtask
   task automatic wait_lat(input int b, input int n);
      int i;
      for (i = 0; i < n && lat[b] !== 1'b1; i++) @(negedge clk);
      if (i == n) begin
         mismatches++;
         $display("MISMATCH latch %0d expected 1 seen 0", b);
         complete_run();
      end
   endtask
   task automatic clear_all();
      far_side_model_i.press(1'b0);
      cyc(2);
      chk("latched", 16'h0000, {7'h00, lat});
   endtask
   task automatic complete_run();
      if (mismatches == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // main sequence
   initial begin
      v = $urandom(78);
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      chk("relay", 16'h0001, {15'h0, relay});
      chk("code", 16'h0000, {12'h0, code});
      chk("exc", 16'h0000, exc);
      ch1.power = 16'd1300;
      temp = 1'b1;
      cyc(4);
      chk("latched", 16'h0000, {7'h00, lat});
      chk("latched", 16'h0000, {7'h00, lat});
      temp = 1'b0;
      cfg_wr(CFG_ENABLES, 16'h0003);
      wait_lat(8, 5);
      e = exc;
      chk("code", 16'h0009, {12'h0, code});
      chk("relay", 16'h0000, {15'h0, relay});
      cyc(5);
      chk("exc", e, exc);
      cyc(HC);
      chk("exc", 16'h0000, exc);
      chk("standby", 16'h0001, {15'h0, stby_o});
      far_side_model_i.press(1'b1);
      far_side_model_i.press(1'b0);
      cyc(2);
      chk("latched", 16'h0100, {7'h00, lat});
      ch1.power = 16'd900;
      clear_all();
      chk("relay", 16'h0001, {15'h0, relay});
      ch1.power = 16'd1100;
      blink_seen(0);
      ch1.power = 16'd1000;
      cyc(1);
      ch1.power = 16'd1100;
      cyc(15);
      chk("latched", 16'h0000, {7'h00, lat});
      wait_lat(8, 30);
      ch1.power = 16'd0;
      clear_all();
      cfg_wr(CFG_PWR_LIM2, 16'd2000);
      ch2.power = 16'd2300;
      cyc(4);
      chk("latched", 16'h0000, {7'h00, lat});
      ch2.power = 16'd0;
      ch2.speed = 16'd5000;
      cyc(4);
      chk("latched", 16'h0000, {7'h00, lat});
      strobe_speed();
      wait_lat(7, 5);
      chk("code", 16'h0008, {12'h0, code});
      // power on one channel and speed on the other latch together
      ch1.power = 16'd1300;
      wait_lat(8, 5);
      chk("latched", 16'h0180, {7'h00, lat});
      chk("code", 16'h0008, {12'h0, code});
      ch1.power = 16'd0;
      ch2.speed = 16'd0;
      strobe_speed();
      clear_all();
      // lowered speed limit: blink, then latch after persistence
      cfg_wr(CFG_SPD_LIM1, 16'd3000);
      ch1.speed = 16'd3500;
      strobe_speed();
      blink_seen(2);
      wait_lat(7, 30);
      ch1.speed = 16'd0;
      strobe_speed();
      clear_all();
      // raised speed limit: blink only, dropped before persistence ends
      cfg_wr(CFG_SPD_LIM2, 16'd6000);
      ch2.speed = 16'd6500;
      strobe_speed();
      blink_seen(3);
      ch2.speed = 16'd0;
      strobe_speed();
      chk("latched", 16'h0000, {7'h00, lat});
      cfg_wr(CFG_ENABLES, 16'h00ff);
      cfg_wr(CFG_GLOB_LIM, 16'd3000);
      tandem = 1'b1;
      gpow = 16'd2500;
      cyc(4);
      chk("latched", 16'h0000, {7'h00, lat});
      pb2 = 1'b1;
      cyc(2);
      chk("latched", 16'h0000, {7'h00, lat});
      cfg_wr(CFG_GLOB_LIM, 16'd2400);
      wait_lat(8, 3);
      chk("relay", 16'h0000, {15'h0, relay});
      gpow = 16'd0;
      clear_all();
      // eddy-current pair arms the global alarm as well
      {pb1, pb2} = 2'b00;
      gpow = 16'd2500;
      wait_lat(8, 3);
      gpow = 16'd0;
      clear_all();
      // mid-run reset: enables off, limits back to defaults
      rst = 1'b1;
      cyc(1);
      rst = 1'b0;
      ch1.power = 16'd700;
      ch2.power = 16'd1300;
      cyc(4);
      chk("latched", 16'h0000, {7'h00, lat});
      cfg_wr(CFG_ENABLES, 16'h00ff);
      wait_lat(8, 5);
      ch2.power = 16'd0;
      clear_all();
      cfg_wr(CFG_PWR_LIM1, 16'd500);
      wait_lat(8, 5);
      ch1.power = 16'd0;
      clear_all();
      supply = 1'b1;
      repeat (8) begin
         v = $urandom;
         {aux, elec, temp} = v[6:0];
         stby = v[7];
         cyc(3);
         chk("code", exp_code({2'b00, v[6:0]}), {12'h0, code});
         chk("latched", {9'h000, v[6:0]}, {7'h00, lat});
         chk("standby", {15'h0, stby}, {15'h0, stby_o});
         {aux, elec, temp} = 7'h00;
         clear_all();
      end
      complete_run();
   end
endmodule
